// file: core/cfb_pkg.sv
// Shared constants and carrier types for the filter-mask and buffer-control block.
// Assumes a 32-bit APB master and neighbouring logic on the same clock.
package cfb_pkg;

    // Sizes of the filter bank, mask bank and buffer set.
    localparam int NUM_FILT = 16;
    localparam int NUM_MASK = 3;
    localparam int NUM_BUF = 32;
    localparam int NUM_CTL_BUF = 8;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] FMSK_LO_OFS = 8'h00;
    localparam logic [7:0] FMSK_HI_OFS = 8'h04;
    localparam logic [7:0] MASK_STD_OFS = 8'h08;
    localparam logic [7:0] MASK_EXT_OFS = 8'h0c;
    localparam logic [7:0] MASK_STRIDE = 8'h08;
    localparam logic [7:0] FULL_LO_OFS = 8'h20;
    localparam logic [7:0] FULL_HI_OFS = 8'h24;
    localparam logic [7:0] OVF_LO_OFS = 8'h28;
    localparam logic [7:0] OVF_HI_OFS = 8'h2c;
    localparam logic [7:0] CTL_OFS = 8'h30;
    localparam logic [7:0] CTL_STRIDE = 8'h04;

    // Field positions in the mask standard word.
    localparam int MSTD_STDID_LSB = 5;
    localparam int MSTD_MODE_BIT = 3;
    localparam int MSTD_EXTID_LSB = 0;

    // Field positions in one byte of a buffer pair control word.
    localparam int CTL_DIR_BIT = 7;
    localparam int CTL_ABT_BIT = 6;
    localparam int CTL_LARB_BIT = 5;
    localparam int CTL_ERR_BIT = 4;
    localparam int CTL_REQ_BIT = 3;
    localparam int CTL_RTR_BIT = 2;
    localparam int CTL_PRI_LSB = 0;

    // Reset values.
    localparam logic [31:0] FMSK_RST = 32'h0000_0000;
    localparam logic [31:0] FLAG_RST = 32'h0000_0000;
    localparam logic [1:0] PRI_RST = 2'h0;

    // Mask source codes of one filter.
    typedef enum logic [1:0] {
        MSK_SEL0 = 2'b00,
        MSK_SEL1 = 2'b01,
        MSK_SEL2 = 2'b10,
        MSK_NONE = 2'b11
    } cfb_msk_src_t;

    // Outcome reported by the transmit engine for one buffer.
    typedef enum logic [1:0] {
        TXE_SENT = 2'b00,
        TXE_ABORTED = 2'b01,
        TXE_LOST_ARB = 2'b10,
        TXE_BUS_ERR = 2'b11
    } cfb_tx_kind_t;

    // Identifier of a received frame offered for filtering.
    typedef struct packed {
        logic valid;
        logic ide;
        logic [10:0] standard_id_bits;
        logic [17:0] extended_id_bits;
    } cfb_frame_t;

    // One acceptance filter as held by the neighbouring filter registers.
    typedef struct packed {
        logic en;
        logic filter_extended_type;
        logic [10:0] standard_id_bits;
        logic [17:0] extended_id_bits;
    } cfb_filt_t;

    // Filter hit result.
    typedef struct packed {
        logic valid;
        logic [4:0] code;
    } cfb_hit_t;

    // Request to store, or permission to write, a received message into a buffer.
    typedef struct packed {
        logic valid;
        logic [4:0] idx;
        logic [4:0] code;
    } cfb_store_t;

    // Transmit engine event.
    typedef struct packed {
        logic valid;
        logic [2:0] idx;
        cfb_tx_kind_t kind;
    } cfb_tx_evt_t;

    // Buffer index carrier for remote requests and the transmit choice.
    typedef struct packed {
        logic valid;
        logic [2:0] idx;
    } cfb_buf_sel_t;

endpackage

// file: core/cfb_top.sv
// Acceptance mask selection, receive full/overflow flags and transmit buffer control.
// Assumes an APB master, a filter register bank, a DMA store path and a transmit engine,
// all on clk_i; none of the inputs need synchronising.
// Function
// (R1) Selector codes 00/01/10 pick masks zero to two.
// (R2) Selector code 11 compares all identifier bits.
// (R3) Two packed selector registers, filter 0 lowest, reset zero.
// (R4) Standard mask bit one compares, zero ignores.
// (R5) Extended mask bits split over two words.
// (R6) Mask mode bit forces identifier type match.
// (R7) Three masks, two words each, unknown reset.
// (R8) Store sets full flag; software clears writing zero.
// (R9) Store into full buffer sets overflow flag.
// (R10) Control word holds even and odd buffer.
// (R11) Direction bit one transmits, resets to receive.
// (R12) Send request cleared after successful send.
// (R13) Clearing pending send request aborts transmission.
// (R14) Status bits read-only, cleared when request set.
// (R15) Remote request sets send request if enabled.
// (R16) Two-bit priority orders pending transmissions.
// (R17) Message contents live in software-placed DMA memory.
// (R18) Type mode: extended bit selects frame type.
// (R19) Receive store writes matching filter code.
// (R20) Match when all included bits are equal.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module cfb_top
    import cfb_pkg::*;
(
    // Clock, reset and freeze.
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Filtering.
    input wire cfb_frame_t frame_i,
    input wire cfb_filt_t filt_i [NUM_FILT],
    output cfb_hit_t hit_o,
    // Receive store path.
    input wire cfb_store_t store_i,
    output cfb_store_t rx_wr_o,
    // Transmit engine.
    input wire cfb_tx_evt_t tx_evt_i,
    input wire cfb_buf_sel_t rtr_rx_i,
    output cfb_buf_sel_t tx_sel_o,
    output logic [NUM_CTL_BUF-1:0] abort_o
);

    // Register state.
    logic [31:0] fmsk_r; // Sixteen 2-bit mask sources, filter 0 at bits 1:0.
    logic [10:0] msid_r [NUM_MASK]; // Standard identifier mask bits.
    logic [17:0] meid_r [NUM_MASK]; // Extended identifier mask bits.
    logic mmode_r [NUM_MASK]; // Identifier type match mode per mask.
    logic [31:0] full_r; // Receive buffer full flags.
    logic [31:0] ovf_r; // Receive buffer overflow flags.
    logic [NUM_CTL_BUF-1:0] dir_r; // One for a transmit buffer.
    logic [NUM_CTL_BUF-1:0] req_r; // Send request.
    logic [NUM_CTL_BUF-1:0] reply_en_r; // Remote auto-reply enable.
    logic [NUM_CTL_BUF-1:0] abt_r; // Aborted status.
    logic [NUM_CTL_BUF-1:0] larb_r; // Lost arbitration status.
    logic [NUM_CTL_BUF-1:0] err_r; // Bus error status.
    logic [1:0] pri_r [NUM_CTL_BUF]; // Transmit priority.
    logic [1:0] sel_pri_r; // Priority of the buffer now offered.

    // Bus decode.
    logic [7:0] addr; // Low address byte.
    logic addr_ok; // Address maps to a register.
    logic wr_en; // Write takes effect at this edge.
    logic [31:0] rd_c; // Read data for the current address.
    logic [7:0] ctl_byte [NUM_CTL_BUF]; // Read view of each control byte.
    logic [NUM_CTL_BUF-1:0] ctl_wr; // Control byte written this edge.
    logic [NUM_FILT-1:0] match_c; // Per-filter match.
    logic [31:0] txbuf_c; // Buffers configured for transmit.
    logic [31:0] st_dec; // One-hot store target.
    logic [31:0] full_clr; // Software clear of full flags.
    logic [31:0] ovf_clr; // Software clear of overflow flags.
    logic [31:0] full_nxt;
    logic [31:0] ovf_nxt;
    logic [1:0] max_pri_c; // Highest priority among pending buffers.
    cfb_buf_sel_t tx_sel_nxt;
    cfb_hit_t hit_nxt;

    assign addr = paddr_i[7:0];
    // Writes land only at the access edge where the answer is given.
    assign wr_en = ce_i && psel_i && penable_i && pready_o && pwrite_i && addr_ok;

    // Address check: word aligned, inside the low 256 bytes, on a mapped offset.
    always_comb begin
        addr_ok = 1'b0;
        if (paddr_i[31:8] == 24'h00_0000 && paddr_i[1:0] == 2'b00) begin
            addr_ok = (addr <= CTL_OFS + 8'h0c);
        end
    end

    // Read mux. Reserved bits read as zero.
    always_comb begin
        rd_c = 32'h0000_0000;
        for (int m = 0; m < NUM_MASK; m++) begin
            if (addr == MASK_STD_OFS + 8'(m) * MASK_STRIDE) begin
                rd_c[15:MSTD_STDID_LSB] = msid_r[m];
                rd_c[MSTD_MODE_BIT] = mmode_r[m];
                rd_c[MSTD_EXTID_LSB+:2] = meid_r[m][17:16];
            end
            if (addr == MASK_EXT_OFS + 8'(m) * MASK_STRIDE) begin
                rd_c[15:0] = meid_r[m][15:0];
            end
        end
        for (int j = 0; j < NUM_CTL_BUF / 2; j++) begin
            if (addr == CTL_OFS + 8'(j) * CTL_STRIDE) begin
                rd_c[15:0] = {ctl_byte[2*j+1], ctl_byte[2*j]}; // R10
            end
        end
        unique case (addr)
            FMSK_LO_OFS: rd_c[15:0] = fmsk_r[15:0];
            FMSK_HI_OFS: rd_c[15:0] = fmsk_r[31:16];
            FULL_LO_OFS: rd_c[15:0] = full_r[15:0];
            FULL_HI_OFS: rd_c[15:0] = full_r[31:16];
            OVF_LO_OFS: rd_c[15:0] = ovf_r[15:0];
            OVF_HI_OFS: rd_c[15:0] = ovf_r[31:16];
            default: begin
            end
        endcase
    end

    // APB answer: no wait state; data and error are captured in the setup cycle.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pready_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else if (ce_i) begin
            if (psel_i && !penable_i) begin
                pready_o <= 1'b1;
                prdata_o <= pwrite_i ? 32'h0000_0000 : rd_c;
                pslverr_o <= !addr_ok;
            end else begin
                pready_o <= 1'b0;
                pslverr_o <= 1'b0;
            end
        end
    end

    // Mask source selectors; both halves reset to zero.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fmsk_r <= FMSK_RST; // R3
        end else if (wr_en && addr == FMSK_LO_OFS) begin
            fmsk_r[15:0] <= pwdata_i[15:0]; // R3
        end else if (wr_en && addr == FMSK_HI_OFS) begin
            fmsk_r[31:16] <= pwdata_i[15:0]; // R3
        end
    end

    // Mask words carry no reset: their contents are unknown until software loads them.
    generate
        for (genvar m = 0; m < NUM_MASK; m++) begin : g_mask
            always_ff @(posedge clk_i) begin
                if (wr_en && addr == MASK_STD_OFS + 8'(m) * MASK_STRIDE) begin
                    msid_r[m] <= pwdata_i[15:MSTD_STDID_LSB]; // R7
                    mmode_r[m] <= pwdata_i[MSTD_MODE_BIT];
                    meid_r[m][17:16] <= pwdata_i[MSTD_EXTID_LSB+:2]; // R5
                end
                if (wr_en && addr == MASK_EXT_OFS + 8'(m) * MASK_STRIDE) begin
                    meid_r[m][15:0] <= pwdata_i[15:0]; // R5
                end
            end
        end
    endgenerate

    // Per-filter comparison against the mask that its selector names.
    generate
        for (genvar f = 0; f < NUM_FILT; f++) begin : g_filt
            logic [28:0] msk; // Bits that take part in the comparison.
            logic mode; // Identifier type must match.
            logic [28:0] diff;
            always_comb begin
                unique case (cfb_msk_src_t'(fmsk_r[2*f+:2]))
                    MSK_SEL0: begin
                        msk = {msid_r[0], meid_r[0]}; // R1
                        mode = mmode_r[0];
                    end
                    MSK_SEL1: begin
                        msk = {msid_r[1], meid_r[1]}; // R1
                        mode = mmode_r[1];
                    end
                    MSK_SEL2: begin
                        msk = {msid_r[2], meid_r[2]}; // R1
                        mode = mmode_r[2];
                    end
                    MSK_NONE: begin
                        msk = {29{1'b1}}; // R2
                        mode = 1'b0;
                    end
                endcase
                // A standard frame has no extended bits, so they never take part.
                diff = ({frame_i.standard_id_bits, frame_i.extended_id_bits}
                        ^ {filt_i[f].standard_id_bits, filt_i[f].extended_id_bits})
                       & msk & {11'h7ff, {18{frame_i.ide}}}; // R4 R5
                match_c[f] = frame_i.valid && filt_i[f].en && (diff == 29'h0) // R20
                             && (!mode || frame_i.ide == filt_i[f].filter_extended_type); // R6 R18
            end
        end
    endgenerate

    // Lowest-numbered matching filter wins the hit code.
    always_comb begin
        hit_nxt = '0;
        for (int f = NUM_FILT - 1; f >= 0; f--) begin
            if (match_c[f]) begin
                hit_nxt.valid = 1'b1;
                hit_nxt.code = 5'(f);
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hit_o <= '0;
        end else if (ce_i) begin
            hit_o <= hit_nxt;
        end
    end

    // Full and overflow flags. A store sets the overflow flag over a same-cycle software clear; a clear of a set full flag wins over a store.
    assign txbuf_c = {24'h00_0000, dir_r};
    assign st_dec = store_i.valid ? (32'h0000_0001 << store_i.idx) : 32'h0000_0000;
    assign full_clr = (wr_en && addr == FULL_LO_OFS) ? {16'h0000, ~pwdata_i[15:0]}
                    : (wr_en && addr == FULL_HI_OFS) ? {~pwdata_i[15:0], 16'h0000} : 32'h0;
    assign ovf_clr = (wr_en && addr == OVF_LO_OFS) ? {16'h0000, ~pwdata_i[15:0]}
                   : (wr_en && addr == OVF_HI_OFS) ? {~pwdata_i[15:0], 16'h0000} : 32'h0;
    assign full_nxt = (full_r & ~full_clr) | (st_dec & ~full_r & ~txbuf_c); // R8
    assign ovf_nxt = (ovf_r & ~ovf_clr) | (st_dec & full_r & ~txbuf_c); // R9

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            full_r <= FLAG_RST;
            ovf_r <= FLAG_RST;
        end else if (ce_i) begin
            full_r <= full_nxt; // R8
            ovf_r <= ovf_nxt; // R9
        end
    end

    // Receive write permission carries the filter code; refused for full or transmit buffers.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_wr_o <= '0;
        end else if (ce_i) begin
            rx_wr_o.valid <= |(st_dec & ~full_r & ~txbuf_c); // R19
            rx_wr_o.idx <= store_i.idx;
            rx_wr_o.code <= store_i.code; // R19
        end
    end

    // Per-buffer transmit control, two buffers to one control word.
    generate
        for (genvar b = 0; b < NUM_CTL_BUF; b++) begin : g_buf
            localparam logic [7:0] OFS = CTL_OFS + 8'(b / 2) * CTL_STRIDE;
            localparam int LANE = 8 * (b % 2);
            logic [7:0] wb; // Byte written to this buffer.
            logic evt; // Engine event for this buffer.
            logic rtr_hit; // Remote request for this buffer.
            logic req_set; // Send request is set this cycle, by software or by a remote request.
            assign wb = pwdata_i[LANE+:8];
            assign ctl_wr[b] = wr_en && addr == OFS; // R10
            assign evt = tx_evt_i.valid && tx_evt_i.idx == 3'(b);
            assign rtr_hit = rtr_rx_i.valid && rtr_rx_i.idx == 3'(b) && reply_en_r[b];
            assign req_set = rtr_hit || (ctl_wr[b] && wb[CTL_REQ_BIT]); // R14
            assign ctl_byte[b] = {dir_r[b], abt_r[b], larb_r[b], err_r[b],
                                  req_r[b], reply_en_r[b], pri_r[b]};

            // Software-owned configuration bits.
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    dir_r[b] <= 1'b0; // R11
                    reply_en_r[b] <= 1'b0;
                    pri_r[b] <= PRI_RST;
                end else if (ce_i && ctl_wr[b]) begin
                    dir_r[b] <= wb[CTL_DIR_BIT]; // R11
                    reply_en_r[b] <= wb[CTL_RTR_BIT];
                    pri_r[b] <= wb[CTL_PRI_LSB+:2];
                end
            end

            // Send request: a remote request or software set wins over the engine's clear.
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    req_r[b] <= 1'b0;
                end else if (ce_i) begin
                    if (rtr_hit) begin
                        req_r[b] <= 1'b1; // R15
                    end else if (ctl_wr[b]) begin
                        req_r[b] <= wb[CTL_REQ_BIT];
                    end else if (evt && (tx_evt_i.kind == TXE_SENT || tx_evt_i.kind == TXE_ABORTED)) begin
                        req_r[b] <= 1'b0; // R12
                    end
                end
            end

            // A zero written over a pending request asks the engine to abort.
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    abort_o[b] <= 1'b0;
                end else if (ce_i) begin
                    abort_o[b] <= ctl_wr[b] && req_r[b] && !wb[CTL_REQ_BIT] && !rtr_hit; // R13
                end
            end

            // Read-only status; an engine event in the same cycle as a new request survives.
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    abt_r[b] <= 1'b0;
                    larb_r[b] <= 1'b0;
                    err_r[b] <= 1'b0;
                end else if (ce_i) begin
                    abt_r[b] <= (abt_r[b] && !req_set)
                                || (evt && tx_evt_i.kind == TXE_ABORTED); // R14
                    larb_r[b] <= (larb_r[b] && !req_set)
                                 || (evt && tx_evt_i.kind == TXE_LOST_ARB); // R14
                    err_r[b] <= (err_r[b] && !req_set)
                                || (evt && tx_evt_i.kind == TXE_BUS_ERR); // R14
                end
            end
        end
    endgenerate

    // Choice of the next buffer to send: highest priority, then lowest index.
    always_comb begin
        tx_sel_nxt = '0;
        max_pri_c = 2'h0;
        for (int b = NUM_CTL_BUF - 1; b >= 0; b--) begin
            if (dir_r[b] && req_r[b] && (!tx_sel_nxt.valid || pri_r[b] >= max_pri_c)) begin
                tx_sel_nxt.valid = 1'b1; // R16
                tx_sel_nxt.idx = 3'(b);
                max_pri_c = pri_r[b];
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_sel_o <= '0;
            sel_pri_r <= 2'h0;
        end else if (ce_i) begin
            tx_sel_o <= tx_sel_nxt; // R16
            sel_pri_r <= max_pri_c;
        end
    end

    // Checks.
    property p_full_set;
        @(posedge clk_i) disable iff (!resetn_i)
        ce_i && store_i.valid && !full_r[store_i.idx] && !txbuf_c[store_i.idx]
        |=> full_r[$past(store_i.idx)] && rx_wr_o.valid && rx_wr_o.code == $past(store_i.code);
    endproperty
    a_full_set: assert property (p_full_set) else $error("store did not set full flag"); // R8

    property p_full_wc;
        @(posedge clk_i) disable iff (!resetn_i)
        ce_i && wr_en && addr == FULL_LO_OFS && pwdata_i[15:0] == 16'hffff && !store_i.valid
        |=> full_r[15:0] == $past(full_r[15:0]);
    endproperty
    a_full_wc: assert property (p_full_wc) else $error("writing ones changed full flags"); // R8

    property p_ovf;
        @(posedge clk_i) disable iff (!resetn_i)
        ce_i && store_i.valid && full_r[store_i.idx] && !txbuf_c[store_i.idx]
        |=> ovf_r[$past(store_i.idx)] && !rx_wr_o.valid;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged"); // R9

    property p_sent;
        @(posedge clk_i) disable iff (!resetn_i)
        ce_i && tx_evt_i.valid && tx_evt_i.idx == 3'h0 && tx_evt_i.kind == TXE_SENT
        && !ctl_wr[0] && !(rtr_rx_i.valid && rtr_rx_i.idx == 3'h0 && reply_en_r[0]) |=> !req_r[0];
    endproperty
    a_sent: assert property (p_sent) else $error("send request not cleared"); // R12

    property p_abort;
        @(posedge clk_i) disable iff (!resetn_i)
        ce_i && ctl_wr[0] && req_r[0] && !pwdata_i[CTL_REQ_BIT] && !rtr_rx_i.valid
        |=> abort_o[0] ##1 (!abort_o[0] || !ce_i);
    endproperty
    a_abort: assert property (p_abort) else $error("abort not pulsed"); // R13

    property p_stat_clr;
        @(posedge clk_i) disable iff (!resetn_i)
        ce_i && ctl_wr[1] && pwdata_i[8+CTL_REQ_BIT] && !tx_evt_i.valid
        |=> !abt_r[1] && !larb_r[1] && !err_r[1] && req_r[1];
    endproperty
    a_stat_clr: assert property (p_stat_clr) else $error("status not cleared on request"); // R14

    property p_rtr;
        @(posedge clk_i) disable iff (!resetn_i)
        ce_i && rtr_rx_i.valid && reply_en_r[rtr_rx_i.idx] |=> req_r[$past(rtr_rx_i.idx)];
    endproperty
    a_rtr: assert property (p_rtr) else $error("remote request ignored"); // R15

    property p_pri;
        @(posedge clk_i) disable iff (!resetn_i)
        ce_i && dir_r[1] && req_r[1] |=> tx_sel_o.valid && sel_pri_r >= $past(pri_r[1]);
    endproperty
    a_pri: assert property (p_pri) else $error("wrong priority chosen"); // R16

    property p_hit;
        @(posedge clk_i) disable iff (!resetn_i)
        ce_i ##1 hit_o.valid |-> ((($past(match_c) >> hit_o.code) & 16'h0001) == 16'h0001)
        && $past(frame_i.valid);
    endproperty
    a_hit: assert property (p_hit) else $error("hit without match"); // R20

    c_overflow: cover property (@(posedge clk_i) disable iff (!resetn_i) ovf_r != 32'h0);
    c_abort: cover property (@(posedge clk_i) disable iff (!resetn_i) abort_o != 8'h00);
    c_hit: cover property (@(posedge clk_i) disable iff (!resetn_i) hit_o.valid ##1 rx_wr_o.valid);
    c_send: cover property (@(posedge clk_i) disable iff (!resetn_i) tx_sel_o.valid ##[1:20] !tx_sel_o.valid);

endmodule

`default_nettype wire

// file: sim/cfb_tx_peer.sv
// Transmit engine stand-in that reports the chosen buffer as sent.
// Assumes the block's clock and reset; hold_i stalls it.
`timescale 1ns/1ps
`default_nettype none
module cfb_tx_peer
    import cfb_pkg::*;
(
    // Clock, reset, choice and stall.
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire cfb_buf_sel_t sel_i,
    input wire logic hold_i,
    // Event back to the block.
    output cfb_tx_evt_t evt_o
);
    logic [1:0] cnt_r; // Cycles the current choice has waited.
    // A slow bus: the frame goes out four cycles after the choice settles.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r <= 2'h0;
            evt_o <= '0;
        end else begin
            evt_o <= '0;
            cnt_r <= (sel_i.valid && !hold_i) ? cnt_r + 2'h1 : 2'h0;
            if (cnt_r == 2'h3) begin
                evt_o <= '{1'b1, sel_i.idx, TXE_SENT};
                cnt_r <= 2'h0;
            end
        end
    end
endmodule
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench: registers, filtering, store flags and transmit control.
// Assumes cfb_top and the cfb_tx_peer engine stand-in.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cfb_pkg::*;
    logic clk_i = 0, resetn_i = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, hold = 0, ab_seen = 0, e;
    logic [31:0] paddr = '0, pwdata = '0, prdata, r;
    logic pready, pslverr;
    logic [NUM_CTL_BUF-1:0] abort;
    cfb_frame_t frame = '0;
    cfb_filt_t filt [NUM_FILT];
    cfb_store_t store = '0, rx_wr;
    cfb_buf_sel_t rtr = '0, tx_sel;
    cfb_tx_evt_t evt;
    cfb_hit_t hit;
    int n_fail = 0, checks_done = 0;
    always #2 clk_i = ~clk_i;
    // Abort pulses last one cycle, so the one of buffer zero is latched.
    always @(posedge clk_i) if (abort[0]) ab_seen <= 1'b1;
    cfb_top u_cfb_top (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .frame_i(frame), .filt_i(filt), .hit_o(hit), .store_i(store), .rx_wr_o(rx_wr),
        .tx_evt_i(evt), .rtr_rx_i(rtr), .tx_sel_o(tx_sel), .abort_o(abort));
    cfb_tx_peer u_cfb_tx_peer (.clk_i(clk_i), .resetn_i(resetn_i), .sel_i(tx_sel), .hold_i(hold), .evt_o(evt));
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
        checks_done++;
        if (g !== x) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, g, x);
        end
    endtask
    // One APB transfer; pready is awaited under a bound, data taken at its edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int i;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= {16'h0, d};
        @(posedge clk_i);
        penable <= 1'b1;
        // Read right after an edge, pready still holds the value sampled at that edge.
        @(posedge clk_i);
        for (i = 1; i < 20 && pready !== 1'b1; i++) @(posedge clk_i);
        if (pready !== 1'b1) begin
            n_fail++;
            results();
        end else begin
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string m);
        apb(1'b0, a, 16'h0);
        chk(r, x, m);
    endtask
    task automatic offer(input logic ide, input logic [10:0] id, input logic [31:0] x);
        @(posedge clk_i);
        frame <= '{1'b1, ide, id, 18'h0};
        @(posedge clk_i);
        frame <= '0;
        #1;
        chk({26'h0, hit}, x, "hit");
    endtask
    task automatic put(input logic [4:0] idx, input logic [31:0] x);
        @(posedge clk_i);
        store <= '{1'b1, idx, 5'h05};
        @(posedge clk_i);
        store <= '0;
        #1;
        chk({21'h0, rx_wr}, x, "store");
    endtask
    task automatic t_regs();
        rdc(FMSK_LO_OFS, 32'h0, "sel lo");
        rdc(FULL_HI_OFS, 32'h0, "full hi");
        rdc(OVF_HI_OFS, 32'h0, "ovf hi");
        rdc(CTL_OFS, 32'h0, "ctl");
        apb(1'b1, FMSK_HI_OFS, 16'he4e4);
        rdc(FMSK_HI_OFS, 32'he4e4, "sel hi");
        rdc(8'h40, 32'h0, "unmapped");
        chk({31'h0, e}, 32'h1, "slverr");
        $display("test regs done");
    endtask
    task automatic t_filter();
        apb(1'b1, MASK_STD_OFS, 16'hffe0);
        apb(1'b1, MASK_STD_OFS + MASK_STRIDE, 16'h0);
        apb(1'b1, MASK_STD_OFS + MASK_STRIDE + MASK_STRIDE, 16'hffc0);
        // Codes 1 and 2 pick masks that ignore the differing low bit.
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, FMSK_LO_OFS, 16'(c));
            offer(1'b0, 11'h122, (c == 1 || c == 2) ? 32'h20 : 32'h0);
        end
        offer(1'b0, 11'h123, 32'h20);
        offer(1'b1, 11'h123, 32'h20);
        // Mask 0 with the type mode on refuses an extended frame at a standard filter.
        apb(1'b1, FMSK_LO_OFS, 16'h0);
        apb(1'b1, MASK_STD_OFS, 16'hffe8);
        offer(1'b1, 11'h123, 32'h0);
        offer(1'b0, 11'h123, 32'h20);
        $display("test filter done");
    endtask
    task automatic t_store();
        put(5'd9, 32'h525);
        rdc(FULL_LO_OFS, 32'h200, "full");
        put(5'd9, 32'h125);
        rdc(OVF_LO_OFS, 32'h200, "ovf");
        apb(1'b1, FULL_LO_OFS, 16'hffff);
        rdc(FULL_LO_OFS, 32'h200, "full kept");
        apb(1'b1, FULL_LO_OFS, 16'h0);
        apb(1'b1, OVF_LO_OFS, 16'h0);
        rdc(FULL_LO_OFS, 32'h0, "full clr");
        rdc(OVF_LO_OFS, 32'h0, "ovf clr");
        // With the clock enable low a store attempt must leave no trace.
        ce <= 1'b0;
        put(5'd3, 32'h0);
        @(posedge clk_i);
        ce <= 1'b1;
        rdc(FULL_LO_OFS, 32'h0, "frozen");
        $display("test store done");
    endtask
    task automatic t_tx();
        apb(1'b1, CTL_OFS, 16'h0088);
        for (int i = 0; i < 10 && r !== 32'h80; i++) apb(1'b0, CTL_OFS, 16'h0);
        chk(r, 32'h80, "sent");
        hold <= 1'b1;
        apb(1'b1, CTL_OFS, 16'h8b89);
        @(posedge clk_i) #1;
        chk({28'h0, tx_sel}, 32'h9, "prio");
        apb(1'b1, CTL_OFS, 16'h8b80);
        repeat (2) @(posedge clk_i);
        chk({31'h0, ab_seen}, 32'h1, "abort");
        apb(1'b1, CTL_OFS + CTL_STRIDE, 16'h0084);
        rtr <= '{1'b1, 3'd2};
        @(posedge clk_i);
        rtr <= '0;
        rdc(CTL_OFS + CTL_STRIDE, 32'h8c, "remote");
        hold <= 1'b0;
        $display("test tx done");
    endtask
    initial begin
        for (int k = 0; k < NUM_FILT; k++) filt[k] = '0;
        filt[0] = '{1'b1, 1'b0, 11'h123, 18'h0};
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_regs();
        t_filter();
        t_store();
        t_tx();
        results();
    end
endmodule
`default_nettype wire
